// ### edst_timer.v
// event driven state timer and pwm generator
//
// Operation
// - one 32-bit or two 16-bit counters, up or up/down
// - each counter ticks on clock or selected input
// - match/capture split, sixteen registers total
// - sixteen events from match, io, direction
// - io condition is rise, fall or level
// - events start, stop or halt the counter
// - limit clears counter or reverses direction
// - match zero acts as automatic limit
// - events qualified by count direction
// - match held pending until other condition
// - events set, clear or toggle outputs
// - firing events capture count into registers
// - events raise interrupt or dma request
// - thirty-two state variable with programmed next
// - per-state enable mask for each event
// - ten single-edge pwm outputs, common period
// - match zero to five dithered fractional edges
`include "edst_map.vh"
module edst_timer #(
    parameter NI = `EDST_NUM_IN,
    parameter NO = `EDST_NUM_OUT,
    parameter NM = `EDST_NUM_MC,
    parameter NE = `EDST_NUM_EV,
    parameter NS = `EDST_NUM_ST,
    parameter SW = `EDST_ST_W,
    parameter NF = `EDST_NUM_FRAC,
    parameter FW = `EDST_FRAC_W
) (
    input  wire             sys_clk_i,
    input  wire             sys_rst_i,
    input  wire [NI-1:0]    ext_in_i,
    input  wire             cfg_unify_i,
    input  wire [1:0]       cfg_bidir_i,
    input  wire [1:0]       cfg_ckin_en_i,
    input  wire [5:0]       cfg_ckin_sel_i,
    input  wire [1:0]       cfg_autolim_i,
    input  wire [NM-1:0]    cfg_cap_mask_i,
    input  wire [1:0]       halt_clr_i,
    input  wire [NM*32-1:0] mat_val_i,
    input  wire [NF*FW-1:0] mat_frac_i,
    input  wire [NE*NS-1:0] ev_state_mask_i,
    input  wire [NE*4-1:0]  ev_match_sel_i,
    input  wire [NE*5-1:0]  ev_io_sel_i,
    input  wire [NE*2-1:0]  ev_io_cond_i,
    input  wire [NE*2-1:0]  ev_comb_i,
    input  wire [NE*2-1:0]  ev_dir_i,
    input  wire [NE-1:0]    ev_hold_i,
    input  wire [NE-1:0]    ev_half_i,
    input  wire [NE-1:0]    ev_st_ld_i,
    input  wire [NE*SW-1:0] ev_next_st_i,
    input  wire [NE-1:0]    act_start_i,
    input  wire [NE-1:0]    act_stop_i,
    input  wire [NE-1:0]    act_halt_i,
    input  wire [NE-1:0]    act_limit_i,
    input  wire [NO*NE-1:0] out_set_i,
    input  wire [NO*NE-1:0] out_clr_i,
    input  wire [NM*NE-1:0] cap_ev_i,
    input  wire [NE-1:0]    irq_en_i,
    input  wire [NE-1:0]    dma_en_i,
    input  wire [NE-1:0]    ev_flag_clr_i,
    output wire [NO-1:0]    pwm_o,
    output wire [31:0]      count_o,
    output wire [1:0]       dir_up_o,
    output wire [1:0]       run_o,
    output wire [1:0]       halted_o,
    output wire [SW-1:0]    state_o,
    output wire [NM*32-1:0] cap_val_o,
    output wire [NE-1:0]    ev_flag_o,
    output wire             irq_o,
    output wire             dma_req_o
);
    localparam IOW = NI + NO;
    localparam [3:0]    RST_RH  = {`EDST_RST_HALT, `EDST_RST_RUN};
    localparam [NO-1:0] RST_OUT = `EDST_RST_OUT;
    reg  [31:0]    cnt_q;
    reg  [31:0]    cnt_d;
    reg  [1:0]     dir_q;
    reg  [1:0]     dir_d;
    reg  [1:0]     run_q;
    reg  [1:0]     halt_q;
    reg  [SW-1:0]  st_q;
    reg  [SW-1:0]  st_d;
    reg  [NO-1:0]  out_q;
    reg  [NO-1:0]  out_prev_q;
    reg  [NE-1:0]  pend_q;
    reg  [NE-1:0]  flag_q;
    reg  [NM*32-1:0] cap_q;
    reg            irq_q;
    reg            dma_q;
    reg  [FW-1:0]  dith_q;
    reg  [32:0]    step_lo;
    reg  [32:0]    step_hi;
    reg  [32:0]    step_un;
    integer        i;
    wire [NI-1:0]  in_lvl;
    wire [NI-1:0]  in_rise;
    wire [NI-1:0]  in_fall;
    wire [1:0]     tick;
    wire [1:0]     adv;
    wire [1:0]     lim;
    wire [NM*2-1:0] hit;
    wire [NE-1:0]  fire;
    wire [NE-1:0]  fire_h0;
    wire [NE-1:0]  fire_h1;
    wire [IOW-1:0] io_lvl;
    wire [IOW-1:0] io_rise;
    wire [IOW-1:0] io_fall;
    function [FW-1:0] bitrev;
        input [FW-1:0] v;
        integer k;
        begin
            for (k = 0; k < FW; k = k + 1)
                bitrev[k] = v[FW-1-k];
        end
    endfunction
    function io_test;
        input       lvl;
        input       rise;
        input       fall;
        input [1:0] cond;
        begin
            case (cond)
                `EDST_IO_LOW:  io_test = ~lvl;
                `EDST_IO_RISE: io_test = rise;
                `EDST_IO_FALL: io_test = fall;
                default:       io_test = lvl;
            endcase
        end
    endfunction
    // returns {up, next}; zero while counting down turns back upward
    function [32:0] cnt_step;
        input [31:0] c;
        input        up;
        input        bi;
        input        lm;
        begin
            if (up && lm && !bi)
                cnt_step = {1'b1, 32'h0000_0000};
            else if (up && lm)
                cnt_step = {1'b0, c - 32'h0000_0001};
            else if (up || lm || c == 32'h0000_0000)
                cnt_step = {1'b1, c + 32'h0000_0001};
            else
                cnt_step = {1'b0, c - 32'h0000_0001};
        end
    endfunction
    edst_insync #(.W (NI)) u_insync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .raw_i     (ext_in_i),
        .lvl_o     (in_lvl),
        .rise_o    (in_rise),
        .fall_o    (in_fall)
    );
    assign io_lvl  = {out_q, in_lvl};
    assign io_rise = {out_q & ~out_prev_q, in_rise};
    assign io_fall = {~out_q & out_prev_q, in_fall};
    // count clock per half: system clock or a selected input edge
    genvar h, m, e, o;
    generate
        for (h = 0; h < 2; h = h + 1) begin : g_tick
            assign tick[h] = cfg_ckin_en_i[h] ? in_rise[cfg_ckin_sel_i[3*h+:3]] : 1'b1;
            assign adv[h]  = tick[h] & run_q[h] & ~halt_q[h];
        end
    endgenerate
    // match compare, dithered on the first match registers
    generate
        for (m = 0; m < NM; m = m + 1) begin : g_mat
            wire [31:0] mv = mat_val_i[32*m+:32];
            wire        dadd;
            if (m < NF) begin : g_dith
                assign dadd = mat_frac_i[FW*m+:FW] > bitrev(dith_q);
            end else begin : g_nodith
                assign dadd = 1'b0;
            end
            wire [31:0] mu = mv + {31'h000_0000, dadd};
            wire [15:0] ml = mv[15:0] + {15'h000, dadd};
            wire [15:0] mh = mv[31:16] + {15'h000, dadd};
            wire        is_mat = ~cfg_cap_mask_i[m];
            assign hit[2*m]   = is_mat & adv[0] &
                                (cfg_unify_i ? (cnt_q == mu) : (cnt_q[15:0] == ml));
            assign hit[2*m+1] = is_mat & adv[1] & ~cfg_unify_i & (cnt_q[31:16] == mh);
            always @(posedge sys_clk_i) begin
                if (sys_rst_i)
                    cap_q[32*m+:32] <= 32'h0000_0000;
                else if (cfg_cap_mask_i[m] && |(fire & cap_ev_i[NE*m+:NE]))
                    cap_q[32*m+:32] <= cnt_q;
            end
        end
    endgenerate
    // event evaluation
    generate
        for (e = 0; e < NE; e = e + 1) begin : g_ev
            wire       hh  = ~cfg_unify_i & ev_half_i[e];
            wire       mhit = hit[{ev_match_sel_i[4*e+:4], hh}];
            wire [4:0] is  = ev_io_sel_i[5*e+:5];
            wire       io_ok = (is < IOW) ?
                               io_test(io_lvl[is], io_rise[is], io_fall[is], ev_io_cond_i[2*e+:2]) : 1'b0;
            wire       mt  = mhit | (ev_hold_i[e] & pend_q[e]);
            wire [1:0] dq  = ev_dir_i[2*e+:2];
            wire       dir_ok = ~cfg_bidir_i[hh] || dq == `EDST_DIR_ANY ||
                                (dq == `EDST_DIR_UP && dir_q[hh]) ||
                                (dq == `EDST_DIR_DOWN && !dir_q[hh]);
            wire       st_ok = ev_state_mask_i[NS*e + st_q];
            wire [1:0] cb  = ev_comb_i[2*e+:2];
            wire       trig = (cb == `EDST_COMB_MATCH) ? mt :
                              (cb == `EDST_COMB_IO)    ? io_ok :
                              (cb == `EDST_COMB_OR)    ? (mt | io_ok) : (mt & io_ok);
            assign fire[e]    = st_ok & dir_ok & trig;
            assign fire_h0[e] = fire[e] & ~hh;
            assign fire_h1[e] = fire[e] & hh;
            always @(posedge sys_clk_i) begin
                if (sys_rst_i)
                    pend_q[e] <= 1'b0;
                else if (fire[e])
                    pend_q[e] <= 1'b0;
                else if (ev_hold_i[e] && mhit)
                    pend_q[e] <= 1'b1;
            end
        end
    endgenerate
    assign lim[0] = (cfg_autolim_i[0] & hit[0]) | |(fire_h0 & act_limit_i);
    assign lim[1] = (cfg_autolim_i[1] & hit[1]) | |(fire_h1 & act_limit_i);
    // counter next value
    always @* begin
        cnt_d   = cnt_q;
        dir_d   = dir_q;
        step_un = cnt_step(cnt_q, dir_q[0], cfg_bidir_i[0], lim[0]);
        step_lo = cnt_step({16'h0000, cnt_q[15:0]}, dir_q[0], cfg_bidir_i[0], lim[0]);
        step_hi = cnt_step({16'h0000, cnt_q[31:16]}, dir_q[1], cfg_bidir_i[1], lim[1]);
        if (cfg_unify_i) begin
            if (adv[0]) begin
                cnt_d = step_un[31:0];
                dir_d = {step_un[32], step_un[32]};
            end
        end else begin
            if (adv[0]) begin
                cnt_d[15:0] = step_lo[15:0];
                dir_d[0]    = step_lo[32];
            end
            if (adv[1]) begin
                cnt_d[31:16] = step_hi[15:0];
                dir_d[1]     = step_hi[32];
            end
        end
    end
    // next state, highest firing event wins
    always @* begin
        st_d = st_q;
        for (i = 0; i < NE; i = i + 1) begin
            if (fire[i] && ev_st_ld_i[i])
                st_d = ev_next_st_i[SW*i+:SW];
        end
    end
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_q  <= 32'h0000_0000;
            dir_q  <= `EDST_RST_DIR;
            st_q   <= `EDST_RST_STATE;
            dith_q <= {FW{1'b0}};
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            st_q  <= st_d;
            if (adv[0] && lim[0])
                dith_q <= dith_q + {{(FW-1){1'b0}}, 1'b1};
        end
    end
    // run and halt per half; halt beats stop beats start
    generate
        for (h = 0; h < 2; h = h + 1) begin : g_run
            wire [NE-1:0] fh = (h == 0 || cfg_unify_i) ? fire_h0 : fire_h1;
            always @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    run_q[h]  <= RST_RH[h];
                    halt_q[h] <= RST_RH[2+h];
                end else if (|(fh & act_halt_i)) begin
                    run_q[h]  <= 1'b0;
                    halt_q[h] <= 1'b1;
                end else if (halt_clr_i[h]) begin
                    run_q[h]  <= 1'b1;
                    halt_q[h] <= 1'b0;
                end else if (|(fh & act_stop_i)) begin
                    run_q[h] <= 1'b0;
                end else if (|(fh & act_start_i) && !halt_q[h]) begin
                    run_q[h] <= 1'b1;
                end
            end
        end
    endgenerate
    // outputs: set, clear, both toggle
    generate
        for (o = 0; o < NO; o = o + 1) begin : g_out
            wire s = |(fire & out_set_i[NE*o+:NE]);
            wire c = |(fire & out_clr_i[NE*o+:NE]);
            always @(posedge sys_clk_i) begin
                if (sys_rst_i)
                    out_q[o] <= RST_OUT[o];
                else if (s && c)
                    out_q[o] <= ~out_q[o];
                else if (s)
                    out_q[o] <= 1'b1;
                else if (c)
                    out_q[o] <= 1'b0;
            end
        end
    endgenerate
    // event flags: a new event wins over a clear in the same cycle
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            out_prev_q <= `EDST_RST_OUT;
            flag_q     <= {NE{1'b0}};
            irq_q      <= 1'b0;
            dma_q      <= 1'b0;
        end else begin
            out_prev_q <= out_q;
            flag_q     <= (flag_q & ~ev_flag_clr_i) | fire;
            irq_q      <= |(((flag_q & ~ev_flag_clr_i) | fire) & irq_en_i);
            dma_q      <= |(fire & dma_en_i);
        end
    end
    assign pwm_o     = out_q;
    assign count_o   = cnt_q;
    assign dir_up_o  = dir_q;
    assign run_o     = run_q;
    assign halted_o  = halt_q;
    assign state_o   = st_q;
    assign cap_val_o = cap_q;
    assign ev_flag_o = flag_q;
    assign irq_o     = irq_q;
    assign dma_req_o = dma_q;
endmodule // edst_timer

// ### edst_map.vh
// constants for the event driven state timer
`ifndef EDST_MAP_VH
`define EDST_MAP_VH

`define EDST_NUM_IN      8
`define EDST_NUM_OUT     10
`define EDST_NUM_MC      16
`define EDST_NUM_EV      16
`define EDST_NUM_ST      32
`define EDST_ST_W        5
`define EDST_NUM_FRAC    6
`define EDST_FRAC_W      4
`define EDST_IO_SEL_W    5

// event io condition codes
`define EDST_IO_LOW      2'h0
`define EDST_IO_RISE     2'h1
`define EDST_IO_FALL     2'h2
`define EDST_IO_HIGH     2'h3

// event trigger combination codes
`define EDST_COMB_OR     2'h0
`define EDST_COMB_MATCH  2'h1
`define EDST_COMB_IO     2'h2
`define EDST_COMB_AND    2'h3

// direction qualifier codes
`define EDST_DIR_ANY     2'h0
`define EDST_DIR_UP      2'h1
`define EDST_DIR_DOWN    2'h2

// reset values
`define EDST_RST_STATE   5'h00
`define EDST_RST_RUN     2'h0
`define EDST_RST_HALT    2'h3
`define EDST_RST_DIR     2'h3
`define EDST_RST_OUT     10'h000

`endif

// ### edst_insync.v
// two flop input synchroniser with edge detect on the settled copy
module edst_insync #(
    parameter W = 8
) (
    input  wire         sys_clk_i,
    input  wire         sys_rst_i,
    input  wire [W-1:0] raw_i,
    output wire [W-1:0] lvl_o,
    output wire [W-1:0] rise_o,
    output wire [W-1:0] fall_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
        end else begin
            s1_q <= raw_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign lvl_o  = s2_q;
    assign rise_o = s2_q & ~s3_q;
    assign fall_o = ~s2_q & s3_q;
endmodule // edst_insync

// ### edst_timer_chk.sv
// assertion checker for the event driven state timer
module edst_timer_chk #(
    parameter NO = 10,
    parameter NE = 16,
    parameter SW = 5
) (
    input wire logic          sys_clk_i,
    input wire logic          sys_rst_i,
    input wire logic          cfg_unify_i,
    input wire logic [1:0]    cfg_bidir_i,
    input wire logic [1:0]    cfg_ckin_en_i,
    input wire logic [1:0]    halt_clr_i,
    input wire logic [NE-1:0] irq_en_i,
    input wire logic [NE-1:0] ev_flag_clr_i,
    input wire logic [31:0]   count_o,
    input wire logic [1:0]    dir_up_o,
    input wire logic [1:0]    run_o,
    input wire logic [1:0]    halted_o,
    input wire logic [SW-1:0] state_o,
    input wire logic [NO-1:0] pwm_o,
    input wire logic [NE-1:0] ev_flag_o,
    input wire logic          irq_o,
    input wire logic          dma_req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_clr;
        cfg_unify_i && halted_o[0] && halt_clr_i[0];
    endsequence
    sequence s_go;
        run_o[0] && !halted_o[0];
    endsequence
    rst_vals_a: assert property (disable iff (1'b0) sys_rst_i |=> count_o == 32'h0 && halted_o == 2'h3
        && run_o == 2'h0 && state_o == '0 && pwm_o == '0 && ev_flag_o == '0 && !dma_req_o)
        else $error("reset values wrong");
    start_walk_a: assert property (s_clr |=> s_go)
        else $error("halt clear did not start counter");
    first_count_a: assert property (s_clr and (count_o == 32'h0 && dir_up_o[0] && !cfg_ckin_en_i[0])
        |=> ##1 count_o == 32'h1)
        else $error("first count wrong");
    up_step_a: assert property (s_go and (cfg_unify_i && !cfg_bidir_i[0] && !cfg_ckin_en_i[0])
        |=> count_o == $past(count_o) + 32'h1 || count_o == 32'h0)
        else $error("counter step wrong");
    halt_freeze_a: assert property (halted_o[0] && cfg_unify_i |=> $stable(count_o))
        else $error("halted counter moved");
    irq_follow_a: assert property (irq_o == |(ev_flag_o & $past(irq_en_i)))
        else $error("irq does not follow flags");
    dma_flag_a: assert property (dma_req_o |-> |ev_flag_o)
        else $error("dma without flag");
    flag_sticky_a: assert property (1'b1 |=> ($past(ev_flag_o) & ~$past(ev_flag_clr_i) & ~ev_flag_o) == '0)
        else $error("flag dropped without clear");
endmodule // edst_timer_chk

bind edst_timer edst_timer_chk #(.NO(NO), .NE(NE), .SW(SW)) u_chk (
    .sys_clk_i     (sys_clk_i),
    .sys_rst_i     (sys_rst_i),
    .cfg_unify_i   (cfg_unify_i),
    .cfg_bidir_i   (cfg_bidir_i),
    .cfg_ckin_en_i (cfg_ckin_en_i),
    .halt_clr_i    (halt_clr_i),
    .irq_en_i      (irq_en_i),
    .ev_flag_clr_i (ev_flag_clr_i),
    .count_o       (count_o),
    .dir_up_o      (dir_up_o),
    .run_o         (run_o),
    .halted_o      (halted_o),
    .state_o       (state_o),
    .pwm_o         (pwm_o),
    .ev_flag_o     (ev_flag_o),
    .irq_o         (irq_o),
    .dma_req_o     (dma_req_o)
);

// ### edst_timer_tb.sv
// self-checking testbench for the event driven state timer
`include "edst_map.vh"
module edst_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic         sys_clk_i = 0, sys_rst_i = 1, cfg_unify_i = 1;
    logic [7:0]   ext_in_i = 0;
    logic [5:0]   cfg_ckin_sel_i = 0;
    logic [1:0]   cfg_bidir_i = 0, cfg_ckin_en_i = 0, cfg_autolim_i = 0, halt_clr_i = 0;
    logic [15:0]  cfg_cap_mask_i = 0, ev_hold_i = 0, ev_half_i = 0, ev_st_ld_i = 0, irq_en_i = 0, dma_en_i = 0;
    logic [15:0]  act_start_i = 0, act_stop_i = 0, act_halt_i = 0, act_limit_i = 0, ev_flag_clr_i = 0;
    logic [31:0]  ev_comb_i = 0, ev_dir_i = 0, ev_io_cond_i = 0;
    logic [63:0]  ev_match_sel_i = 0;
    logic [79:0]  ev_io_sel_i = 0, ev_next_st_i = 0;
    logic [159:0] out_set_i = 0, out_clr_i = 0;
    logic [255:0] cap_ev_i = 0;
    logic [511:0] mat_val_i = 0, ev_state_mask_i = 0;
    logic [23:0]  mat_frac_i = 0;
    logic [9:0]   pwm_o;
    logic [31:0]  count_o;
    logic [1:0]   dir_up_o, run_o, halted_o;
    logic [4:0]   state_o;
    logic [511:0] cap_val_o;
    logic [15:0]  ev_flag_o;
    logic         irq_o, dma_req_o;
    int           fail_count = 0, n_tests = 0, cyc = 0;

    edst_timer dut (.*);

    always #50 sys_clk_i = ~sys_clk_i;

    task tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #10;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task give_verdict;
        if (fail_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // reset three edges to flush the input synchroniser, then start
    task go(input [1:0] h);
        sys_rst_i = 1;
        tick(3);
        sys_rst_i = 0;
        halt_clr_i = h;
        tick(1);
        halt_clr_i = 0;
    endtask

    task t_count;
        cfg_unify_i = 1;
        go(2'h3);
        chk(run_o[0], 1'b1);
        tick(3);
        chk(count_o, 32'h0000_0003);
        cfg_unify_i = 0;
        go(2'h2);
        tick(5);
        chk(count_o, 32'h0005_0000);
    endtask

    task t_ckin;
        cfg_unify_i = 1;
        cfg_ckin_en_i = 2'h1;
        cfg_ckin_sel_i = 6'h03;
        go(2'h3);
        repeat (3) begin
            ext_in_i[3] = 1;
            tick(3);
            ext_in_i[3] = 0;
            tick(3);
        end
        tick(4);
        chk(count_o, 32'h0000_0003);
        cfg_ckin_en_i = 0;
    endtask

    task t_limit;
        for (int bi = 0; bi < 2; bi++) begin
            cfg_bidir_i = bi[1:0];
            cfg_autolim_i = 2'h1;
            mat_val_i[31:0] = 32'h0000_0004;
            go(2'h3);
            tick(5);
            chk(count_o, bi ? 32'h0000_0003 : 32'h0000_0000);
            chk(dir_up_o[0], bi ? 1'b0 : 1'b1);
        end
        cfg_bidir_i = 0;
        cfg_autolim_i = 0;
    endtask

    task t_event;
        ev_comb_i[3:0] = {`EDST_COMB_MATCH, `EDST_COMB_MATCH};
        ev_match_sel_i[7:0] = 8'h21;
        mat_val_i[95:32] = {32'h0000_0006, 32'h0000_0003};
        ev_state_mask_i[0] = 1;
        ev_state_mask_i[39] = 1;
        ev_st_ld_i[0] = 1;
        ev_next_st_i[4:0] = 5'h07;
        out_set_i[32] = 1;
        out_clr_i[33] = 1;
        cap_ev_i[80] = 1;
        cfg_cap_mask_i[5] = 1;
        irq_en_i[0] = 1;
        dma_en_i[0] = 1;
        act_stop_i[1] = 1;
        go(2'h3);
        tick(4);
        chk(pwm_o[2], 1'b1);
        chk(state_o, 5'h07);
        chk(dma_req_o, 1'b1);
        chk(ev_flag_o, 16'h0001);
        chk(cap_val_o[191:160], 32'h0000_0003);
        tick(1);
        chk({irq_o, dma_req_o}, 2'h2);
        tick(2);
        chk(pwm_o[2], 1'b0);
        chk(run_o[0], 1'b0);
        tick(3);
        chk(count_o, 32'h0000_0007);
        ev_flag_clr_i = 16'h0001;
        tick(1);
        ev_flag_clr_i = 0;
        tick(2);
        chk({ev_flag_o[0], irq_o}, 2'h0);
    endtask

    // input edge halts and sets pwm3; held match then fires on pwm3 high
    task t_io;
        ev_state_mask_i = 0;
        ev_state_mask_i[64] = 1;
        ev_state_mask_i[96] = 1;
        ev_comb_i[7:4] = {`EDST_COMB_AND, `EDST_COMB_IO};
        ev_io_cond_i[7:4] = {`EDST_IO_HIGH, `EDST_IO_RISE};
        ev_io_sel_i[19:10] = 10'h160;
        ev_match_sel_i[15:12] = 4'h1;
        ev_hold_i[3] = 1;
        act_halt_i[2] = 1;
        out_set_i[50] = 1;
        out_set_i[67] = 1;
        go(2'h1);
        tick(4);
        chk(pwm_o[4:3], 2'h0);
        ext_in_i[0] = 1;
        tick(4);
        chk({pwm_o[4:3], halted_o[0]}, 3'h7);
        chk(count_o, 32'h0000_0007);
        ext_in_i[0] = 0;
    endtask

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        tick(12);
        t_count();
        t_ckin();
        t_limit();
        t_event();
        t_io();
        give_verdict();
    end
endmodule // edst_timer_tb
